// [pkg/lsp_defs.svh]
// register offsets, field positions, reset values and counts of the serial port
`ifndef LSP_DEFS_SVH
`define LSP_DEFS_SVH
`define LSP_OFS_COMMAND 8'h22
`define LSP_OFS_DATA 8'h23
`define LSP_OFS_STATUS 8'h24
`define LSP_OFS_CONFIG 8'h25
`define LSP_CMD_DIR_BIT 0
`define LSP_STAT_DONE_BIT 0
`define LSP_STAT_FULL_BIT 1
`define LSP_CFG_IER_BIT 0
`define LSP_CFG_RATE_BIT 6
`define LSP_CFG_TARGET_BIT 7
`define LSP_RST_BYTE 8'h00
`define LSP_DIR_WRITE 1'b0
`define LSP_DIR_READ 1'b1
`define LSP_WORD_LAST 4'hf
`define LSP_RX_FIRST 4'h8
`define LSP_SLOW_LAST 3'h7
`define LSP_FIFO_DEPTH 8
`endif

// [pkg/lsp_pkg.sv]
// types shared by the serial control port
package lsp_pkg;
   typedef enum logic [1:0] {LSP_IDLE, LSP_SHIFT} lsp_state_e;
   typedef struct packed
   {
      logic [7:0] data;
      logic [6:0] remote_register_index;
      logic transfer_direction;
   } lsp_word_s;
   typedef struct packed
   {
      logic target_select;
      logic shift_rate_select;
      logic completion_irq_enable;
   } lsp_cfg_s;
   typedef struct packed
   {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr_en;
      logic rd_en;
   } lsp_cpu_s;
endpackage

// [logic/lsp_sync.sv]
// three-stage synchroniser; a level changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module lsp_sync #(
   parameter int WIDTH = 1
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] change
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   logic [WIDTH-1:0] lvl_q;

   if (WIDTH < 1)
   begin : g_chk
      $error("lsp_sync: WIDTH must be at least 1");
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end
      else
      begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // per bit: follow only when the two settled stages agree
   for (genvar i = 0; i < WIDTH; i++)
   begin : g_bit
      always_ff @(posedge core_clk or negedge resetn)
      begin
         if (!resetn)
            lvl_q[i] <= 1'b0;
         else if (s2_q[i] == s3_q[i])
            lvl_q[i] <= s3_q[i];
      end
      assign change[i] = (s2_q[i] == s3_q[i]) && (s3_q[i] != lvl_q[i]);
   end

   assign level = lvl_q;
endmodule
`default_nettype wire

// [logic/lsp_fifo.sv]
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module lsp_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
   begin : g_chk
      $error("lsp_fifo: DEPTH must be a power of two >= 2");
   end

   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge core_clk)
   begin
      if (push)
         mem_q[wr_q] <= in_data;
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
            wr_q <= wr_q + AW'(1);
         if (pop)
            rd_q <= rd_q + AW'(1);
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

// [logic/lsp_serial_port.sv]
// serial control port master toward the line interface chip
`timescale 1ns/1ps
`default_nettype none
`include "lsp_defs.svh"
module lsp_serial_port #(
   parameter int FIFO_DEPTH = `LSP_FIFO_DEPTH
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire lsp_pkg::lsp_cpu_s cpu,
   output logic [7:0] cpu_rdata,
   input wire logic shift_ref_clk,
   input wire logic serial_din,
   output logic serial_clk,
   output logic serial_dout,
   output logic chip_select_one_n,
   output logic chip_select_two_n,
   output logic irq_out_n
);
   import lsp_pkg::*;

   lsp_state_e state_q;
   lsp_word_s serial_command_q;
   logic [7:0] transfer_byte_q;
   lsp_cfg_s serial_configuration_q;
   logic transfer_complete_q;
   logic [7:0] rdata_q;
   logic irq_n_q;
   logic sclk_q;
   logic dout_q;
   logic cs1_n_q;
   logic cs2_n_q;
   logic [15:0] shift_q;
   logic [7:0] rx_q;
   logic [3:0] bit_q;
   logic phase_q;
   logic is_read_q;
   logic [2:0] slow_q;
   logic [1:0] sync_lvl;
   logic [1:0] sync_chg;
   logic tick;
   logic q_ready;
   logic q_valid;
   lsp_word_s q_word;
   logic wr_cmd;
   logic start;
   logic finish;
   logic stat_read;

   function automatic logic hit(input lsp_cpu_s c, input logic [7:0] ofs);
      hit = (c.addr == ofs);
   endfunction

   // the queue logic needs at least two entries
   if (FIFO_DEPTH < 2)
   begin : g_chk
      $error("lsp_serial_port: FIFO_DEPTH must be at least 2");
   end

   lsp_sync #(
      .WIDTH(2)
   ) u_sync (
      .core_clk(core_clk),
      .resetn(resetn),
      .async_in({serial_din, shift_ref_clk}),
      .level(sync_lvl),
      .change(sync_chg)
   );

   // command and its data are queued together so back-to-back
   // commands keep the data that was current when each was written
   lsp_fifo #(
      .WIDTH($bits(lsp_word_s)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .core_clk(core_clk),
      .resetn(resetn),
      .in_valid(wr_cmd),
      .in_ready(q_ready),
      .in_data({transfer_byte_q, cpu.wdata}),
      .out_valid(q_valid),
      .out_ready(state_q == LSP_IDLE),
      .out_data(q_word)
   );

   // a command written while the queue is full is dropped; status shows it
   assign wr_cmd = cpu.wr_en && hit(cpu, `LSP_OFS_COMMAND);
   assign start = q_valid && (state_q == LSP_IDLE);
   assign finish = (state_q == LSP_SHIFT) && tick && phase_q
                   && (bit_q == `LSP_WORD_LAST);
   assign stat_read = cpu.rd_en && hit(cpu, `LSP_OFS_STATUS);

   // fast rate ticks on every reference edge, slow rate on every eighth
   assign tick = sync_chg[0]
                 && (serial_configuration_q.shift_rate_select
                     || slow_q == `LSP_SLOW_LAST);

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         slow_q <= '0;
      else if (sync_chg[0])
         slow_q <= slow_q + 3'h1;
   end

   // processor-visible registers
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         serial_command_q <= '0;
         serial_configuration_q <= '0;
      end
      else if (cpu.wr_en)
      begin
         if (hit(cpu, `LSP_OFS_COMMAND))
            serial_command_q <= {transfer_byte_q, cpu.wdata};
         if (hit(cpu, `LSP_OFS_CONFIG))
         begin
            // reserved bits are not stored and read back as zero
            serial_configuration_q.target_select <=
               cpu.wdata[`LSP_CFG_TARGET_BIT];
            serial_configuration_q.shift_rate_select <=
               cpu.wdata[`LSP_CFG_RATE_BIT];
            serial_configuration_q.completion_irq_enable <=
               cpu.wdata[`LSP_CFG_IER_BIT];
         end
      end
   end

   // a finishing read beats a simultaneous processor write
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         transfer_byte_q <= `LSP_RST_BYTE;
      else if (finish && is_read_q)
         transfer_byte_q <= rx_q;
      else if (cpu.wr_en && hit(cpu, `LSP_OFS_DATA))
         transfer_byte_q <= cpu.wdata;
   end

   // set wins over the clear by a status read
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         transfer_complete_q <= 1'b0;
      else if (finish)
         transfer_complete_q <= 1'b1;
      else if (start || state_q != LSP_IDLE)
         transfer_complete_q <= 1'b0;
      else if (stat_read)
         transfer_complete_q <= 1'b0;
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         irq_n_q <= 1'b1;
      else
         irq_n_q <= !(transfer_complete_q
                      && serial_configuration_q.completion_irq_enable);
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         rdata_q <= '0;
      else if (cpu.rd_en)
      begin
         rdata_q <= '0;
         unique case (cpu.addr)
            `LSP_OFS_COMMAND: rdata_q <= serial_command_q[7:0];
            `LSP_OFS_DATA: rdata_q <= transfer_byte_q;
            `LSP_OFS_STATUS:
            begin
               rdata_q[`LSP_STAT_DONE_BIT] <= transfer_complete_q;
               rdata_q[`LSP_STAT_FULL_BIT] <= !q_ready;
            end
            `LSP_OFS_CONFIG:
            begin
               rdata_q[`LSP_CFG_TARGET_BIT] <=
                  serial_configuration_q.target_select;
               rdata_q[`LSP_CFG_RATE_BIT] <=
                  serial_configuration_q.shift_rate_select;
               rdata_q[`LSP_CFG_IER_BIT] <=
                  serial_configuration_q.completion_irq_enable;
            end
            default: rdata_q <= '0;
         endcase
      end
   end

   // shift engine: rising serial clock samples, falling edge moves on
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_q <= LSP_IDLE;
         shift_q <= '0;
         rx_q <= '0;
         bit_q <= '0;
         phase_q <= 1'b0;
         is_read_q <= 1'b0;
         sclk_q <= 1'b0;
         dout_q <= 1'b0;
      end
      else
      begin
         unique case (state_q)
            LSP_IDLE:
            begin
               if (start)
               begin
                  // {data, index, dir} shifted right: dir, index lsb first
                  shift_q <= q_word;
                  dout_q <= q_word.transfer_direction;
                  is_read_q <= (q_word.transfer_direction
                                == `LSP_DIR_READ);
                  bit_q <= '0;
                  phase_q <= 1'b0;
                  state_q <= LSP_SHIFT;
               end
            end
            LSP_SHIFT:
            begin
               if (tick && !phase_q)
               begin
                  sclk_q <= 1'b1;
                  phase_q <= 1'b1;
                  if (is_read_q && bit_q >= `LSP_RX_FIRST)
                     rx_q <= {sync_lvl[1], rx_q[7:1]};
               end
               else if (tick)
               begin
                  sclk_q <= 1'b0;
                  phase_q <= 1'b0;
                  if (finish)
                  begin
                     state_q <= LSP_IDLE;
                     dout_q <= 1'b0;
                  end
                  else
                  begin
                     bit_q <= bit_q + 4'h1;
                     shift_q <= {1'b0, shift_q[15:1]};
                     // a read releases the line after the command byte
                     dout_q <= (is_read_q && bit_q >= 4'h7)
                               ? 1'b0 : shift_q[1];
                  end
               end
            end
            default: state_q <= LSP_IDLE;
         endcase
      end
   end

   // selects follow the engine; target sampled at the start only
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cs1_n_q <= 1'b1;
         cs2_n_q <= 1'b1;
      end
      else if (start)
      begin
         cs1_n_q <= serial_configuration_q.target_select;
         cs2_n_q <= !serial_configuration_q.target_select;
      end
      else if (finish)
      begin
         cs1_n_q <= 1'b1;
         cs2_n_q <= 1'b1;
      end
   end

   assign cpu_rdata = rdata_q;
   assign serial_clk = sclk_q;
   assign serial_dout = dout_q;
   assign chip_select_one_n = cs1_n_q;
   assign chip_select_two_n = cs2_n_q;
   assign irq_out_n = irq_n_q;

   // check-only count of serial clock rises since the transaction began
   logic [4:0] rise_cnt_q;
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         rise_cnt_q <= '0;
      else if (start)
         rise_cnt_q <= '0;
      else if (state_q == LSP_SHIFT && tick && !phase_q)
         rise_cnt_q <= rise_cnt_q + 5'h1;
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   a_cmd_starts: assert property (wr_cmd && q_ready && !q_valid
      && state_q == LSP_IDLE |=> ##1 state_q == LSP_SHIFT)
      else $error("command write did not start a transaction");
   a_word_length: assert property (finish |-> rise_cnt_q == 5'h10)
      else $error("transaction did not span sixteen bits");
   a_read_release: assert property (state_q == LSP_SHIFT && is_read_q
      && bit_q >= `LSP_RX_FIRST |-> !dout_q)
      else $error("line not released during read data");
   a_cmd_index: assert property (start
      |=> shift_q[7:1] == $past(q_word.remote_register_index))
      else $error("register index not loaded behind direction");
   a_read_capture: assert property (finish && is_read_q
      |=> transfer_byte_q == $past(rx_q))
      else $error("read data not stored");
   a_first_bit: assert property (start
      |=> dout_q == $past(q_word.transfer_direction))
      else $error("direction bit not first on the line");
   a_dir_decode: assert property (start
      |=> is_read_q == $past(q_word.transfer_direction))
      else $error("direction decode wrong");
   a_done_busy: assert property (state_q == LSP_SHIFT && !finish
      |=> !transfer_complete_q)
      else $error("completion flag set while busy");
   a_done_set: assert property (finish
      |=> transfer_complete_q ##1 (irq_n_q
          == !serial_configuration_q.completion_irq_enable
          || $past(cpu.wr_en)))
      else $error("completion or interrupt wrong after finish");
   a_stat_clear: assert property (stat_read && !finish
      |=> !transfer_complete_q ##1 irq_n_q)
      else $error("status read did not clear flag and interrupt");
   a_cs_target: assert property (start
      |=> cs1_n_q == $past(serial_configuration_q.target_select)
          && cs2_n_q != cs1_n_q)
      else $error("wrong chip select driven");
   a_cs_held: assert property (state_q == LSP_SHIFT
      |-> cs1_n_q != cs2_n_q)
      else $error("chip select dropped mid transaction");

   c_write_done: cover property (finish && !is_read_q);
   c_read_done: cover property (finish && is_read_q);
   c_slow_rate: cover property (tick && !serial_configuration_q
      .shift_rate_select);
   c_queue_full: cover property (wr_cmd && !q_ready);
endmodule
`default_nettype wire

// [verif/lsp_liu_model.sv]
// behavioural line interface chip on the far side of the serial port
`timescale 1ns/1ps
`default_nettype none
module lsp_liu_model (
   input wire logic serial_clk,
   input wire logic cs_n,
   input wire logic serial_dout,
   output logic serial_din,
   output logic [15:0] word,
   output var int nwords
);
   logic [7:0] regs [0:127];
   logic [15:0] sr;
   int cnt;
   initial
   begin
      for (int i = 0; i < 128; i++)
         regs[i] = 8'(i) ^ 8'h5a;
      serial_din = 1'b0;
      word = 16'h0000;
      sr = 16'h0000;
      nwords = 0;
      cnt = 0;
   end
   always @(negedge cs_n)
      cnt = 0;
   // direction first, then index and data lsb first
   always @(posedge serial_clk)
      if (!cs_n && cnt < 16)
      begin
         sr[cnt] = serial_dout;
         cnt = cnt + 1;
      end
   // read data lsb first, set up a half bit ahead of the rise
   always @(negedge serial_clk)
      if (!cs_n && sr[0] && cnt >= 8 && cnt < 16)
         serial_din = regs[sr[7:1]][cnt-8];
   // released line flips, so a stale bit cannot pass for data
   always @(posedge cs_n)
   begin
      serial_din = ~serial_din;
      word = sr;
      if (cnt == 16)
      begin
         nwords = nwords + 1;
         if (!sr[0])
            regs[sr[7:1]] = sr[15:8];
      end
   end
endmodule
`default_nettype wire

// [verif/liu_serial_control_port_bench.sv]
// self-checking bench for the serial control port master
`timescale 1ns/1ps
`default_nettype none
module liu_serial_control_port_bench;
   import lsp_pkg::*;
   logic core_clk, resetn, shift_ref_clk, serial_din, serial_clk;
   logic serial_dout, cs1_n, cs2_n, irq_out_n, din_a, din_b;
   logic seen_one, seen_two;
   lsp_cpu_s cpu;
   logic [7:0] cpu_rdata, d;
   logic [15:0] word_a, word_b;
   int nw_a, nw_b, num_errors, n_checks, cycles, fast_len, slow_len;
   assign serial_din = cs1_n ? din_b : din_a;
   lsp_serial_port #(.FIFO_DEPTH(8)) i_dut (.core_clk(core_clk),
      .resetn(resetn), .cpu(cpu), .cpu_rdata(cpu_rdata),
      .shift_ref_clk(shift_ref_clk), .serial_din(serial_din),
      .serial_clk(serial_clk), .serial_dout(serial_dout),
      .chip_select_one_n(cs1_n), .chip_select_two_n(cs2_n),
      .irq_out_n(irq_out_n));
   lsp_liu_model i_liu_a (.serial_clk(serial_clk), .cs_n(cs1_n),
      .serial_dout(serial_dout), .serial_din(din_a), .word(word_a),
      .nwords(nw_a));
   lsp_liu_model i_liu_b (.serial_clk(serial_clk), .cs_n(cs2_n),
      .serial_dout(serial_dout), .serial_din(din_b), .word(word_b),
      .nwords(nw_b));
   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   // reference phase offset keeps it unrelated to the core clock
   initial
   begin
      shift_ref_clk = 1'b0;
      #7;
      forever #40 shift_ref_clk = ~shift_ref_clk;
   end
   task automatic finish_test;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic check(input string name, input logic [15:0] seen,
                        input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
      @(posedge core_clk);
      cpu <= '{addr: a, wdata: v, wr_en: 1'b1, rd_en: 1'b0};
      @(posedge core_clk);
      cpu <= '0;
   endtask
   task automatic reg_read(input logic [7:0] a, output logic [7:0] v);
      @(posedge core_clk);
      cpu <= '{addr: a, wdata: 8'h00, wr_en: 1'b0, rd_en: 1'b1};
      @(posedge core_clk);
      cpu <= '0;
      #1;
      v = cpu_rdata;
   endtask
   // one command; records which select fell and how long it stayed low
   task automatic run_xfer(input logic [7:0] cmd, output int len);
      int n;
      logic [7:0] s;
      n = 0;
      len = 0;
      reg_write(8'h22, cmd);
      while (cs1_n && cs2_n && n < 100)
      begin
         @(posedge core_clk);
         #1;
         n++;
      end
      seen_one = !cs1_n;
      seen_two = !cs2_n;
      reg_read(8'h24, s);
      check("done while busy", s[0], 1'b0);
      while (!(cs1_n && cs2_n) && len < 4000)
      begin
         @(posedge core_clk);
         #1;
         seen_one |= !cs1_n;
         seen_two |= !cs2_n;
         len++;
      end
      check("transfer ended", len < 4000, 1'b1);
      repeat (3) @(posedge core_clk);
      #1;
   endtask
   task automatic t_regs;
      for (int a = 8'h22; a <= 8'h25; a++)
      begin
         reg_read(8'(a), d);
         check("reset value", d, 8'h00);
      end
      reg_write(8'h25, 8'hc1); // reserved bits left zero
      reg_read(8'h25, d);
      check("config readback", d, 8'hc1);
      reg_write(8'h23, 8'ha5);
      reg_read(8'h23, d);
      check("data readback", d, 8'ha5);
      reg_write(8'h26, 8'hff);
      reg_read(8'h26, d);
      check("unmapped read", d, 8'h00);
   endtask
   task automatic t_write;
      reg_write(8'h25, 8'h41);
      reg_write(8'h23, 8'h3c);
      run_xfer(8'h2a, fast_len);
      check("write word", word_a, {8'h3c, 7'h15, 1'b0});
      check("select one", {seen_one, seen_two}, 2'b10);
      check("irq raised", irq_out_n, 1'b0);
      reg_read(8'h24, d);
      check("done set", d[0], 1'b1);
      repeat (2) @(posedge core_clk);
      #1;
      check("irq withdrawn", irq_out_n, 1'b1);
      reg_read(8'h24, d);
      check("done cleared", d[0], 1'b0);
   endtask
   task automatic t_read;
      int len;
      reg_write(8'h25, 8'hc0);
      run_xfer(8'h2b, len);
      check("read word", word_b, {8'h00, 8'h2b});
      check("select two", {seen_one, seen_two}, 2'b01);
      check("irq masked", irq_out_n, 1'b1);
      reg_read(8'h23, d);
      check("read data", d, 8'h15 ^ 8'h5a);
      reg_read(8'h24, d);
      check("read done", d[0], 1'b1);
   endtask
   task automatic t_slow;
      reg_write(8'h25, 8'h00);
      reg_write(8'h23, 8'h96);
      run_xfer(8'h7e, slow_len);
      check("slow word", word_a, 16'h967e);
      check("rate ratio", slow_len > 6 * fast_len
            && slow_len < 10 * fast_len, 1'b1);
      reg_read(8'h24, d);
      check("slow done", d[0], 1'b1);
   endtask
   task automatic t_queue;
      int base, n;
      reg_write(8'h25, 8'h40);
      base = nw_a;
      n = 0;
      for (int i = 0; i < 10; i++)
      begin
         reg_write(8'h23, 8'(i * 3 + 1));
         reg_write(8'h22, {7'(i + 32), 1'b0});
      end
      reg_read(8'h24, d);
      check("queue full", d[1], 1'b1);
      while (nw_a < base + 9 && n < 8000)
      begin
         @(posedge core_clk);
         n++;
      end
      // long enough for a dropped tenth command to show up
      repeat (800) @(posedge core_clk);
      check("queued count", 16'(nw_a - base), 16'd9);
      for (int i = 0; i < 9; i++)
         check("queued data", i_liu_a.regs[32 + i], 8'(i * 3 + 1));
      check("dropped command", i_liu_a.regs[41], 8'd41 ^ 8'h5a);
      reg_read(8'h24, d);
      check("queue drained", d[1:0], 2'b01);
   endtask
   always @(posedge core_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 40000)
      begin
         num_errors++;
         finish_test;
      end
   end
   initial
   begin
      num_errors = 0;
      n_checks = 0;
      cycles = 0;
      resetn = 1'b0;
      cpu = '0;
      repeat (6) @(posedge core_clk);
      resetn <= 1'b1;
      t_regs;
      t_write;
      t_read;
      t_slow;
      t_queue;
      finish_test;
   end
endmodule
`default_nettype wire
